// ==== core/tmac_core.sv ====
// test mode timer, speed filter, aux pin functions and register slave
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "tmac_defines.svh"
// Function
// - power-up starts test mode for thirty seconds
// - commanded test mode ends after ten minutes
// - test mode ignores thresholds, accepts 20-100
// - test mode clears speed at once
// - normal mode rejects non-directional returns
// - configuration query ends test mode
// - continuous trigger: transmit while pin low
// - start-stop trigger toggles after each release
// - lock mode: car only, pulses toggle lock
// - alarm output low below threshold, else high
// - audio square wave proportional to speed
// - squelch silences audio without target
// - normal mode drops readings outside thresholds
// - firmware reload restores defaults, keeps address
// - one speed message per poll request
module tmac_core
  import tmac_pkg::*;
#(
  parameter int unsigned TICK_CYC       = (`TMAC_TICK_MS * 1000000) / `TMAC_CLK_NS,
  parameter int unsigned FORK_PWR_TICKS = (`TMAC_FORK_PWR_S * 1000) / `TMAC_TICK_MS,
  parameter int unsigned FORK_CMD_TICKS = (`TMAC_FORK_CMD_MIN * 60000) / `TMAC_TICK_MS
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   s_axi_awvalid_i,
  input  wire logic [`TMAC_ADDR_W-1:0] s_axi_awaddr_i,
  output logic                        s_axi_awready_o,
  input  wire logic                   s_axi_wvalid_i,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  output logic                        s_axi_wready_o,
  output logic                        s_axi_bvalid_o,
  output logic [1:0]                  s_axi_bresp_o,
  input  wire logic                   s_axi_bready_i,
  input  wire logic                   s_axi_arvalid_i,
  input  wire logic [`TMAC_ADDR_W-1:0] s_axi_araddr_i,
  output logic                        s_axi_arready_o,
  output logic                        s_axi_rvalid_o,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  input  wire logic                   s_axi_rready_i,
  input  wire logic                   sample_valid_i,
  input  wire logic [7:0]             sample_speed_i,
  input  wire logic [1:0]             sample_dir_i,
  input  wire logic                   aux_in_i,
  output logic                        aux_o,
  output logic                        aux_oe_o,
  output logic                        tx_on_o,
  output logic                        speed_valid_o,
  output logic [7:0]                  speed_o,
  output logic                        irq_o
);
  localparam int CW = `TMAC_FORK_CNT_W;
  localparam int TW = `TMAC_TICK_CNT_W;

  // refuse counts that the counters cannot hold
  if (TICK_CYC < 2 || TICK_CYC > (1 << TW) || FORK_CMD_TICKS >= (1 << CW)
      || FORK_PWR_TICKS >= (1 << CW) || FORK_PWR_TICKS < 1) begin : g_chk
    $error("tmac_core: timing parameters out of range");
  end

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // bus and register state
  logic                   awready_r, awready_nxt;
  logic                   wready_r, wready_nxt;
  logic                   aw_got_r, aw_got_nxt;   // address captured
  logic                   w_got_r, w_got_nxt;     // data captured
  logic [`TMAC_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]            wdata_r, wdata_nxt;
  logic [3:0]             wstrb_r, wstrb_nxt;
  logic                   bvalid_r, bvalid_nxt;
  logic [1:0]             bresp_r, bresp_nxt;
  logic                   arready_r, arready_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [1:0]             rresp_r, rresp_nxt;
  tmac_ctrl_s             ctrl_r, ctrl_nxt;       // steering bits
  tmac_thr_s              thr_r, thr_nxt;         // speed thresholds
  logic [7:0]             busadr_r, busadr_nxt;   // serial bus address
  logic [`TMAC_IRQ_W-1:0] ist_r, ist_nxt;         // sticky events
  logic [`TMAC_IRQ_W-1:0] imask_r, imask_nxt;     // event mask
  logic [8:0]             poll_r, poll_nxt;       // latched speed message
  logic                   irq_r, irq_nxt;
  // command strobes of a write
  logic                   cmd_fork, cmd_qry, cmd_poll;
  // events from the other groups
  logic [`TMAC_IRQ_W-1:0] ev;
  logic                   ev_fork;                // test mode ended
  logic                   ev_aux;                 // aux trigger edge
  // fork timer state
  tmac_fork_e             fork_r, fork_nxt;
  logic [CW-1:0]          fcnt_r, fcnt_nxt;       // remaining ticks
  logic [TW-1:0]          tcnt_r, tcnt_nxt;       // tick divider
  logic                   tick;
  // speed state
  logic [7:0]             spd_r, spd_nxt;
  logic                   sval_r, sval_nxt;
  logic [7:0]             clr_r, clr_nxt;         // auto-clear ticks left
  // aux state
  logic                   prev_r, prev_nxt;       // last pin level
  logic                   ss_r, ss_nxt;           // start-stop transmit state
  logic                   lock_r, lock_nxt;       // live speed locked
  logic [7:0]             lspd_r, lspd_nxt;       // locked speed
  logic [15:0]            phase_r, phase_nxt;     // audio accumulator
  logic                   tx_r, tx_nxt;
  logic                   aux_r, aux_nxt;
  logic                   oe_r, oe_nxt;

  // register slave: handshakes, decode, write effects
  always_comb begin
    logic [`TMAC_ADDR_W-1:0] wa;
    logic [31:0]             wd;
    logic [3:0]              ws;
    logic                    wfire;
    wa = awaddr_r;
    wd = wdata_r;
    ws = wstrb_r;
    wfire = 1'b0;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    thr_nxt = thr_r;
    busadr_nxt = busadr_r;
    imask_nxt = imask_r;
    poll_nxt = poll_r;
    ist_nxt = ist_r;
    cmd_fork = 1'b0;
    cmd_qry = 1'b0;
    cmd_poll = 1'b0;
    // address and data taken in either order
    if (s_axi_awvalid_i && awready_r) begin
      wa = s_axi_awaddr_i;
      awaddr_nxt = s_axi_awaddr_i;
      aw_got_nxt = 1'b1;
    end
    if (s_axi_wvalid_i && wready_r) begin
      wd = s_axi_wdata_i;
      ws = s_axi_wstrb_i;
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
      w_got_nxt = 1'b1;
    end
    if (bvalid_r && s_axi_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
      wfire = 1'b1;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `TMAC_RESP_OK;
    end
    if (wfire) begin
      case (wa)
        `TMAC_CTRL_OFF: begin
          // command bits are strobes, the rest is stored
          if (ws[0]) begin
            cmd_fork = wd[`TMAC_CTRL_FORK_BIT];
            cmd_qry = wd[`TMAC_CTRL_QRY_BIT];
          end
          if (ws[1]) begin
            ctrl_nxt = tmac_ctrl_s'(wd[14:8]);
          end
          if (ws[0] && wd[`TMAC_CTRL_LOAD_BIT]) begin
            ctrl_nxt = tmac_ctrl_s'(`TMAC_CTRL_RST);
            thr_nxt = tmac_thr_s'(`TMAC_THR_RST);
          end
        end
        `TMAC_THR_OFF:      thr_nxt = tmac_thr_s'(merge(thr_r, wd, ws));
        `TMAC_ADDR_OFF:     busadr_nxt = ws[0] ? wd[7:0] : busadr_r;
        `TMAC_IRQ_MASK_OFF: imask_nxt = ws[0] ? wd[`TMAC_IRQ_W-1:0] : imask_r;
        `TMAC_IRQ_STAT_OFF: ist_nxt = ws[0] ? (ist_r & ~wd[`TMAC_IRQ_W-1:0]) : ist_r;
        `TMAC_POLL_OFF:     cmd_poll = 1'b1;
        `TMAC_STAT_OFF:     ;
        default:            bresp_nxt = `TMAC_RESP_ERR;
      endcase
    end
    // one speed message latched per request
    if (cmd_poll) begin
      poll_nxt = {sval_r, spd_r};
    end
    // set wins over a clear in the same cycle
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & imask_nxt);
    // read channel
    if (rvalid_r && s_axi_rready_i) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid_i && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `TMAC_RESP_OK;
      case (s_axi_araddr_i)
        `TMAC_CTRL_OFF:     rdata_nxt = {17'h0, ctrl_r, 8'h00};
        `TMAC_THR_OFF:      rdata_nxt = thr_r;
        `TMAC_ADDR_OFF:     rdata_nxt = {24'h0, busadr_r};
        `TMAC_STAT_OFF:     rdata_nxt = {8'h00, lspd_r, spd_r, 4'h0, sval_r, lock_r,
                                         tx_r, fork_r};
        `TMAC_IRQ_STAT_OFF: rdata_nxt = {29'h0, ist_r};
        `TMAC_IRQ_MASK_OFF: rdata_nxt = {29'h0, imask_r};
        `TMAC_POLL_OFF:     rdata_nxt = {23'h0, poll_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `TMAC_RESP_ERR;
        end
      endcase
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
  end

  // fork timer on a fixed tick
  always_comb begin
    fork_nxt = fork_r;
    fcnt_nxt = fcnt_r;
    tick = (tcnt_r == TW'(TICK_CYC - 1));
    tcnt_nxt = tick ? '0 : tcnt_r + 1'b1;
    ev_fork = 1'b0;
    if (fork_r == TMAC_FORK_ON && tick) begin
      if (fcnt_r <= CW'(1)) begin
        fork_nxt = TMAC_FORK_OFF;
        ev_fork = 1'b1;
      end else begin
        fcnt_nxt = fcnt_r - 1'b1;
      end
    end
    if (cmd_qry && fork_r == TMAC_FORK_ON) begin
      fork_nxt = TMAC_FORK_OFF;
      ev_fork = 1'b1;
    end
    if (cmd_fork) begin
      fork_nxt = TMAC_FORK_ON;
      fcnt_nxt = CW'(FORK_CMD_TICKS);
    end
  end

  // speed filter and auto-clear
  always_comb begin
    logic acc;
    acc = 1'b0;
    spd_nxt = spd_r;
    sval_nxt = sval_r;
    clr_nxt = clr_r;
    if (fork_r == TMAC_FORK_ON) begin
      acc = sample_valid_i && sample_speed_i >= `TMAC_FORK_MIN_MPH
            && sample_speed_i <= `TMAC_FORK_MAX_MPH;
    end else begin
      acc = sample_valid_i && sample_dir_i != 2'b00
            && sample_speed_i >= thr_r.low && sample_speed_i <= thr_r.high;
    end
    if (acc) begin
      spd_nxt = sample_speed_i;
      sval_nxt = 1'b1;
      clr_nxt = thr_r.autoclr;
    end else if (sval_r) begin
      if (fork_r == TMAC_FORK_ON || clr_r == 8'h00) begin
        spd_nxt = 8'h00;
        sval_nxt = 1'b0;
      end else if (tick) begin
        clr_nxt = clr_r - 1'b1;
      end
    end
  end

  // aux pin functions and transmitter
  always_comb begin
    logic fall;
    logic rise;
    fall = prev_r && !aux_in_i;
    rise = !prev_r && aux_in_i;
    prev_nxt = aux_in_i;
    ss_nxt = 1'b0;
    lock_nxt = 1'b0;
    lspd_nxt = lspd_r;
    phase_nxt = 16'h0000;
    tx_nxt = ctrl_r.tx_gate;
    aux_nxt = 1'b0;
    oe_nxt = 1'b0;
    ev_aux = 1'b0;
    case (ctrl_r.mode)
      TMAC_AUX_CONT: begin
        tx_nxt = ctrl_r.tx_gate || !aux_in_i;
        ev_aux = fall;
      end
      TMAC_AUX_SS: begin
        ss_nxt = rise ? !ss_r : ss_r;
        tx_nxt = ctrl_r.tx_gate || ss_nxt;
        ev_aux = rise;
      end
      TMAC_AUX_LOCK: begin
        if (ctrl_r.car) begin
          tx_nxt = 1'b1;
          lock_nxt = fall ? !lock_r : lock_r;
          if (fall && !lock_r) begin
            lspd_nxt = spd_r;
          end
          ev_aux = fall;
        end
      end
      TMAC_AUX_ALARM: begin
        oe_nxt = 1'b1;
        aux_nxt = sval_r && spd_r >= thr_r.alarm;
      end
      TMAC_AUX_AUDIO: begin
        oe_nxt = 1'b1;
        phase_nxt = phase_r + {8'h00, spd_r};
        aux_nxt = phase_r[15];
        if (ctrl_r.squelch && !sval_r) begin
          aux_nxt = 1'b0;
          phase_nxt = 16'h0000;
        end
      end
      default: ;
    endcase
  end

  // event vector gathered in one place, one driver per bit
  always_comb begin
    ev = '0;
    ev[`TMAC_IRQ_FORK_END] = ev_fork;
    ev[`TMAC_IRQ_POLL] = cmd_poll;
    ev[`TMAC_IRQ_AUX] = ev_aux;
  end

  // all state registered here
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `TMAC_RESP_OK;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `TMAC_RESP_OK;
      ctrl_r <= tmac_ctrl_s'(`TMAC_CTRL_RST);
      thr_r <= tmac_thr_s'(`TMAC_THR_RST);
      busadr_r <= `TMAC_BUSADR_RST;
      ist_r <= '0;
      imask_r <= '0;
      poll_r <= 9'h000;
      irq_r <= 1'b0;
      fork_r <= TMAC_FORK_ON;
      fcnt_r <= CW'(FORK_PWR_TICKS);
      tcnt_r <= '0;
      spd_r <= 8'h00;
      sval_r <= 1'b0;
      clr_r <= 8'h00;
      prev_r <= 1'b1;
      ss_r <= 1'b0;
      lock_r <= 1'b0;
      lspd_r <= 8'h00;
      phase_r <= 16'h0000;
      tx_r <= 1'b0;
      aux_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      busadr_r <= busadr_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      poll_r <= poll_nxt;
      irq_r <= irq_nxt;
      fork_r <= fork_nxt;
      fcnt_r <= fcnt_nxt;
      tcnt_r <= tcnt_nxt;
      spd_r <= spd_nxt;
      sval_r <= sval_nxt;
      clr_r <= clr_nxt;
      prev_r <= prev_nxt;
      ss_r <= ss_nxt;
      lock_r <= lock_nxt;
      lspd_r <= lspd_nxt;
      phase_r <= phase_nxt;
      tx_r <= tx_nxt;
      aux_r <= aux_nxt;
      oe_r <= oe_nxt;
    end
  end

  // outputs straight from flops
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign aux_o = aux_r;
  assign aux_oe_o = oe_r;
  assign tx_on_o = tx_r;
  assign speed_valid_o = sval_r;
  assign speed_o = spd_r;
  assign irq_o = irq_r;
endmodule

// ==== include/tmac_defines.svh ====
// register map, reset values and timing figures of the test mode and aux pin block
`ifndef TMAC_DEFINES_SVH
`define TMAC_DEFINES_SVH
`define TMAC_ADDR_W        8
`define TMAC_CTRL_OFF      8'h00
`define TMAC_THR_OFF       8'h04
`define TMAC_ADDR_OFF      8'h08
`define TMAC_STAT_OFF      8'h0C
`define TMAC_IRQ_STAT_OFF  8'h10
`define TMAC_IRQ_MASK_OFF  8'h14
`define TMAC_POLL_OFF      8'h18
`define TMAC_CTRL_FORK_BIT 0
`define TMAC_CTRL_QRY_BIT  1
`define TMAC_CTRL_LOAD_BIT 2
`define TMAC_CTRL_RST      7'h10
`define TMAC_THR_RST       32'h0A3CC805
`define TMAC_BUSADR_RST    8'h02
`define TMAC_IRQ_W         3
`define TMAC_IRQ_FORK_END  0
`define TMAC_IRQ_POLL      1
`define TMAC_IRQ_AUX       2
`define TMAC_FORK_MIN_MPH  8'h14
`define TMAC_FORK_MAX_MPH  8'h64
`define TMAC_CLK_NS        25
`define TMAC_TICK_MS       1
`define TMAC_FORK_PWR_S    30
`define TMAC_FORK_CMD_MIN  10
`define TMAC_FORK_CNT_W    20
`define TMAC_TICK_CNT_W    16
`define TMAC_RESP_OK       2'h0
`define TMAC_RESP_ERR      2'h2
`endif

// ==== include/tmac_pkg.sv ====
// types of the test mode and aux pin block
package tmac_pkg;
  typedef enum logic [2:0] {
    TMAC_AUX_OFF   = 3'b000,
    TMAC_AUX_CONT  = 3'b001,
    TMAC_AUX_SS    = 3'b010,
    TMAC_AUX_LOCK  = 3'b011,
    TMAC_AUX_ALARM = 3'b100,
    TMAC_AUX_AUDIO = 3'b101
  } tmac_aux_e;
  typedef enum logic {
    TMAC_FORK_OFF = 1'b0,
    TMAC_FORK_ON  = 1'b1
  } tmac_fork_e;
  typedef struct packed {
    logic      car;
    logic      tx_gate;
    tmac_aux_e mode;
    logic      squelch;
    logic      spare;
  } tmac_ctrl_s;
  typedef struct packed {
    logic [7:0] autoclr;
    logic [7:0] alarm;
    logic [7:0] high;
    logic [7:0] low;
  } tmac_thr_s;
endpackage

// ==== sim/tmac_core_props.sv ====
// port-level assertions of the test mode and aux pin block
`timescale 1ns/100ps
module tmac_core_props #(
  parameter int unsigned TICK_CYC       = 4, // clocks per tick
  parameter int unsigned FORK_PWR_TICKS = 5  // power-up test length
) (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rready_i,
  input wire logic        sample_valid_i,
  input wire logic [7:0]  sample_speed_i,
  input wire logic [1:0]  sample_dir_i,
  input wire logic        speed_valid_o,
  input wire logic [7:0]  speed_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  localparam int EARLY = (FORK_PWR_TICKS - 2) * TICK_CYC; // surely still in test
  localparam int LATE  = (FORK_PWR_TICKS + 2) * TICK_CYC; // surely over
  logic [15:0] cyc_r;   // clocks since reset
  logic [15:0] cyc_nxt;
  logic        wr_r;    // any write seen since reset
  logic        wr_nxt;
  logic        nd;      // non-directional sample present
  assign nd = sample_valid_i && (sample_dir_i == 2'h0);
  // saturating age counter and write flag
  always_comb begin
    cyc_nxt = (cyc_r == 16'hFFFF) ? cyc_r : cyc_r + 16'h1;
    wr_nxt  = wr_r | (s_axi_awvalid_i & s_axi_awready_o);
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_r <= 16'h0;
      wr_r  <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      wr_r  <= wr_nxt;
    end
  end
  // sample drop followed by a quiet cycle
  sequence s_drop;
    $fell(sample_valid_i) ##1 !sample_valid_i;
  endsequence
  property p_pwr_on;
    (cyc_r < EARLY) && nd && sample_speed_i >= 8'h14 && sample_speed_i <= 8'h64
      |=> speed_valid_o && speed_o == $past(sample_speed_i);
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("test tone not shown");
  property p_pwr_off;
    (cyc_r > LATE) && !wr_r && nd && !speed_valid_o |=> !speed_valid_o;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("tone shown late");
  property p_nd_rng;
    $rose(speed_valid_o) && $past(sample_dir_i) == 2'h0 |-> speed_o >= 8'h14 && speed_o <= 8'h64;
  endproperty
  a_nd_rng: assert property (p_nd_rng) else $error("tone out of range");
  property p_fork_clr;
    (cyc_r < EARLY) ##0 s_drop |-> ##[0:1] !speed_valid_o;
  endproperty
  a_fork_clr: assert property (p_fork_clr) else $error("speed not cleared");
  property p_b_ans;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_ans;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read response");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule

// ==== sim/tmac_sw_model.sv ====
// trigger switch on the aux pin, pull-up to high when open
`timescale 1ns/100ps
module tmac_sw_model (
  input  wire logic press_i,  // switch grounds the pin
  input  wire logic aux_o_i,  // block drive value
  input  wire logic aux_oe_i, // block drives the pin
  output logic      pin_o     // resolved pin level
);
  // a driving block wins, else pull-up unless grounded
  assign pin_o = aux_oe_i ? aux_o_i : !press_i;
endmodule

// ==== sim/tb_tmac_core.sv ====
// self-checking bench of the test mode and aux pin block
`timescale 1ns/100ps
module tb_tmac_core;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clock_i = 1'b0, rst_b_i = 1'b0, pr = 1'b0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, sample_valid_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, sample_speed_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, d;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  sample_dir_i = 2'h0, s_axi_bresp_o, s_axi_rresp_o, rs, wb;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        aux_in_i, aux_o, aux_oe_o, tx_on_o, speed_valid_o, irq_o;
  logic [31:0] s_axi_rdata_o;
  logic [7:0]  speed_o;
  logic [7:0]  spd [4] = '{8'h32, 8'h3C, 8'h3B, 8'h64}; // alarm speeds
  logic [3:0]  alm = 4'hA;                              // alarm levels
  int          num_errors = 0, total_checks = 0, cyc = 0;
  tmac_core #(.TICK_CYC(4), .FORK_PWR_TICKS(5), .FORK_CMD_TICKS(20)) u_dut (.*);
  tmac_sw_model u_sw (.press_i(pr), .aux_o_i(aux_o), .aux_oe_i(aux_oe_o), .pin_o(aux_in_i));
  always #12.5 clock_i = ~clock_i;
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 15000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one write; handshakes judged at the falling edge before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb, go;
    go = 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (go) begin
      @(negedge clock_i);
      ha = s_axi_awvalid_i && s_axi_awready_o;
      hw = s_axi_wvalid_i && s_axi_wready_o;
      hb = s_axi_bvalid_o;
      wb = s_axi_bresp_o;
      @(posedge clock_i);
      if (ha) s_axi_awvalid_i <= 1'b0;
      if (hw) s_axi_wvalid_i <= 1'b0;
      if (hb) begin
        s_axi_bready_i <= 1'b0;
        go = 1'b0;
      end
    end
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ha, hr, go;
    go = 1'b1;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    while (go) begin
      @(negedge clock_i);
      ha = s_axi_arvalid_i && s_axi_arready_o;
      hr = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clock_i);
      if (ha) s_axi_arvalid_i <= 1'b0;
      if (hr) begin
        s_axi_rready_i <= 1'b0;
        go = 1'b0;
      end
    end
    @(posedge clock_i);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a, d, rs);
    ck(d & m, e);
  endtask
  task automatic smp(input logic v, input logic [7:0] s, input logic [1:0] dr);
    sample_valid_i <= v;
    sample_speed_i <= s;
    sample_dir_i <= dr;
    @(posedge clock_i);
  endtask
  task automatic sp(input logic [8:0] e);
    @(negedge clock_i);
    ck({speed_valid_o, speed_o}, e);
    @(posedge clock_i);
  endtask
  task automatic ir(input logic e);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    ck(irq_o, e);
    @(posedge clock_i);
  endtask
  // switch press or release, then transmitter state
  task automatic pp(input logic v, input logic e);
    pr <= v;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    ck(tx_on_o, e);
    @(posedge clock_i);
  endtask
  // rising edges of the audio output over a fixed span
  task automatic ae(input logic v, input logic [7:0] s, input int lo, input int hi);
    logic l;
    int c;
    c = 0;
    l = aux_o;
    smp(v, s, 2'h1);
    repeat (2000) begin
      @(negedge clock_i);
      if (aux_o === 1'b1 && l === 1'b0) c++;
      l = aux_o;
    end
    ck(c >= lo && c <= hi, 1'b1);
    @(posedge clock_i);
  endtask
  // stored control fields, transmitter gate left at hold
  function automatic logic [31:0] cw(input logic c, input logic [2:0] md, input logic q);
    return {17'h0, c, 1'b0, md, q, 1'b0, 8'h00};
  endfunction
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    smp(1'b1, 8'h32, 2'h0);
    sample_valid_i <= 1'b0;
    sp(9'h132);
    smp(1'b0, 8'h00, 2'h0);
    sp(9'h000);
    smp(1'b1, 8'h0A, 2'h0);
    sample_valid_i <= 1'b0;
    sp(9'h000);
    repeat (40) @(posedge clock_i);
    smp(1'b1, 8'h32, 2'h0);
    sp(9'h000);
    smp(1'b1, 8'h03, 2'h1);
    sp(9'h000);
    smp(1'b1, 8'hC9, 2'h2);
    sp(9'h000);
    smp(1'b1, 8'h32, 2'h1);
    sp(9'h132);
    smp(1'b0, 8'h00, 2'h0);
    sp(9'h132);
    rc(8'h00, 32'h1000, 32'h7F00);
    rc(8'h04, 32'h0A3CC805, ALL);
    rc(8'h08, 32'h2, ALL);
    rd(8'h1C, d, rs);
    ck(d, 32'h0);
    ck(rs, 2'h2);
    wr(8'h1C, 32'h0);
    ck(wb, 2'h2);
    wr(8'h14, 32'h0);
    ck(wb, 2'h0);
    wr(8'h00, 32'h1001);
    rc(8'h0C, 32'h1, 32'h1);
    smp(1'b1, 8'h32, 2'h0);
    sample_valid_i <= 1'b0;
    sp(9'h132);
    repeat (30) @(posedge clock_i);
    wr(8'h00, 32'h1001);
    repeat (55) @(posedge clock_i);
    rc(8'h0C, 32'h1, 32'h1);
    repeat (40) @(posedge clock_i);
    rc(8'h0C, 32'h0, 32'h1);
    rc(8'h10, 32'h1, 32'h1);
    ir(1'b0);
    wr(8'h14, 32'h1);
    ir(1'b1);
    wr(8'h14, 32'h0);
    ir(1'b0);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h1);
    ir(1'b0);
    wr(8'h00, 32'h1001);
    wr(8'h00, 32'h1002);
    rc(8'h0C, 32'h0, 32'h1);
    ir(1'b1);
    wr(8'h00, cw(1'b0, 3'h1, 1'b0));
    pp(1'b1, 1'b1);
    pp(1'b0, 1'b0);
    wr(8'h00, cw(1'b0, 3'h2, 1'b0));
    pp(1'b1, 1'b0);
    pp(1'b0, 1'b1);
    pp(1'b1, 1'b1);
    pp(1'b0, 1'b0);
    smp(1'b1, 8'h32, 2'h1);
    wr(8'h00, cw(1'b1, 3'h3, 1'b0));
    pp(1'b1, 1'b1);
    rc(8'h0C, 32'h320004, 32'hFF0004);
    pp(1'b0, 1'b1);
    pp(1'b1, 1'b1);
    rc(8'h0C, 32'h0, 32'h4);
    pp(1'b0, 1'b1);
    wr(8'h00, cw(1'b0, 3'h4, 1'b0));
    for (int i = 0; i < 4; i++) begin
      smp(1'b1, spd[i], 2'h2);
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      ck({aux_oe_o, aux_o}, {1'b1, alm[i]});
      @(posedge clock_i);
    end
    smp(1'b0, 8'h00, 2'h0);
    wr(8'h00, cw(1'b0, 3'h5, 1'b1));
    repeat (60) @(posedge clock_i);
    ae(1'b0, 8'h00, 0, 0);
    ae(1'b1, 8'hC8, 5, 7);
    ae(1'b1, 8'h64, 2, 4);
    smp(1'b1, 8'h4D, 2'h1);
    wr(8'h18, 32'h0);
    rc(8'h18, 32'h14D, 32'h1FF);
    smp(1'b1, 8'h58, 2'h1);
    repeat (4) @(posedge clock_i);
    rc(8'h18, 32'h14D, 32'h1FF);
    rc(8'h10, 32'h2, 32'h2);
    wr(8'h18, 32'h0);
    rc(8'h18, 32'h158, 32'h1FF);
    wr(8'h08, 32'h33);
    wr(8'h04, 32'h01020304);
    s_axi_wstrb_i <= 4'h1;
    wr(8'h00, 32'h4);
    s_axi_wstrb_i <= 4'hF;
    rc(8'h00, 32'h1000, 32'h7F00);
    rc(8'h04, 32'h0A3CC805, ALL);
    rc(8'h08, 32'h33, 32'hFF);
    test_done();
  end
endmodule
bind tmac_core tmac_core_props #(.TICK_CYC(TICK_CYC), .FORK_PWR_TICKS(FORK_PWR_TICKS)) u_props (.*);
